// File: logic/bmt_transfer_ctrl.sv
// start-up transfer controller between terminal and backup module
// assumes switch pins static at start-up; source streams words with valid/ready
// Behaviour
// - sample both switch banks once at start-up
// - restore switch copies module into terminal
// - backup switch copies terminal into module
// - manual switch takes direction, bank from panel
// - data type: off screen, on system
// - terminal write enable gates terminal writes
// - module write enable gates module writes
// - bank switch picks bank 0 or 1
// - module holds two independent banks
// - several mode switches on gives mode error
// - no mode switch on gives mode error
// - protected destination gives protect error
// - non-system data into system area errors
// - system program into screen area errors
// - backup ignores terminal's own configuration
// - module write touches addressed bank only
// - never normal operation while module attached
// - combined: system bank 0, screen bank 1
// - combined restore needs exactly one system bank
// - run lamp: 1 s prep, 0.5 s xmit, lit done; stays dark throughout manual runs
`timescale 1ns/1ps
module bmt_transfer_ctrl (
  input  wire logic                         clk,               // system clock
  input  wire logic                         sys_rst,           // sync reset, high
  input  wire bmt_pkg::bmt_switch_s         switches,          // selector banks
  input  wire logic                         module_present,    // module attached
  input  wire logic                         bank0_holds_sys,   // bank 0 type tag
  input  wire logic                         bank1_holds_sys,   // bank 1 type tag
  input  wire logic                         panel_execute,     // manual go pulse
  input  wire logic                         panel_to_module,   // manual direction
  input  wire logic                         panel_bank,        // manual bank
  input  wire logic                         src_valid,         // source word valid
  output logic                              src_ready,         // source may send
  input  wire bmt_pkg::bmt_word_s           src_word,          // source word
  input  wire logic                         src_last,          // last source word
  output logic                              src_request,       // source must stream
  output logic                              src_from_module,   // source is module
  output logic                              src_bank,          // source bank
  output logic                              src_sys,           // source sys area
  output logic                              dst_valid,         // dest word valid
  input  wire logic                         dst_ready,         // dest accepts
  output bmt_pkg::bmt_word_s                dst_word,          // dest word
  output logic                              dst_to_module,     // dest is module
  input  wire logic                         verify_done,       // verify finished
  input  wire logic                         verify_ok,         // verify matched
  output logic                              verify_start,      // verify request
  output bmt_pkg::bmt_err_s                 err_flags,         // error class
  output bmt_pkg::bmt_state_e               xfer_state,        // progress state
  output logic                              run_lamp,          // run indicator
  output logic                              normal_run_allow   // may enter run
);

  bmt_pkg::bmt_state_e  state_ff, nxt_state;
  bmt_pkg::bmt_switch_s sw_ff;
  bmt_pkg::bmt_err_s    err_ff, nxt_err;
  logic                 sampled_ff;
  logic                 to_module_ff, nxt_to_module;
  logic                 bank_ff, nxt_bank;
  logic                 sys_ff, nxt_sys;
  logic                 combined_ff, nxt_combined;
  logic                 phase_ff, nxt_phase;
  logic                 done_once_ff;
  logic                 lamp_ff;
  logic [25:0]          blink_ff;
  logic                 verr_ff;

  // two-entry skid buffer
  bmt_pkg::bmt_word_s   buf_ff [bmt_pkg::BUF_DEPTH];
  logic                 wptr_ff, rptr_ff;
  logic [1:0]           cnt_ff;

  // switch decode
  wire logic [1:0] mode_cnt   = 2'(sw_ff.restore_mode_select)
                              + 2'(sw_ff.backup_mode_select)
                              + 2'(sw_ff.manual_mode_select);
  wire logic mode_bad         = (mode_cnt != 2'h1);
  wire logic auto_restore     = sw_ff.restore_mode_select;
  wire logic auto_backup      = sw_ff.backup_mode_select;
  wire logic combined         = sw_ff.combined_transfer_enable;
  wire logic sel_sys          = sw_ff.data_type_select;
  wire logic sel_bank         = sw_ff.bank_select;
  wire logic want_module_dst  = auto_backup | (sw_ff.manual_mode_select & panel_to_module);
  wire logic protect_bad      = want_module_dst ? ~sw_ff.module_write_enable
                                                : ~sw_ff.terminal_write_enable;
  wire logic one_sys_bank     = bank0_holds_sys ^ bank1_holds_sys;
  // manual runs take the bank from the panel, automatic ones from the switch
  wire logic eff_bank         = sw_ff.manual_mode_select ? panel_bank : sel_bank;
  wire logic chosen_sys_bank  = eff_bank ? bank1_holds_sys : bank0_holds_sys;
  // restore into the terminal: bank content must match the target area
  wire logic data_bad         = ~want_module_dst & (combined ? ~one_sys_bank
                                : (sel_sys ? ~chosen_sys_bank
                                           : chosen_sys_bank));
  wire logic manual_go        = sw_ff.manual_mode_select & panel_execute;
  wire logic start_auto       = sampled_ff & ~done_once_ff & (auto_restore | auto_backup);

  // buffer handshakes
  wire logic buf_full         = (cnt_ff == 2'(bmt_pkg::BUF_DEPTH));
  wire logic buf_empty        = (cnt_ff == 2'h0);
  wire logic xmit_active      = (state_ff == bmt_pkg::ST_XMIT);
  wire logic push             = src_valid & src_ready;
  wire logic pop              = dst_valid & dst_ready;
  wire logic last_popped      = pop & buf_ff[rptr_ff].last;
  // combined backup: system words go to bank 0, screen words to bank 1
  wire logic word_bank        = combined_ff ? (src_word.sys_area ? bmt_pkg::BANK_SYS
                                                                 : bmt_pkg::BANK_SCR)
                                            : bank_ff;

  assign src_ready        = xmit_active & ~buf_full;
  assign dst_valid        = xmit_active & ~buf_empty & (err_ff == '0);
  assign dst_word         = buf_ff[rptr_ff];
  assign src_request      = xmit_active;
  assign src_from_module  = ~to_module_ff;
  assign src_bank         = bank_ff;
  assign src_sys          = sys_ff;
  assign dst_to_module    = to_module_ff;
  assign verify_start     = (state_ff == bmt_pkg::ST_VERIFY) & ~phase_ff;
  assign err_flags        = err_ff;
  assign xfer_state       = state_ff;
  assign run_lamp         = lamp_ff;
  assign normal_run_allow = ~module_present & sampled_ff;

  // next-state logic
  always_comb begin
    nxt_state     = state_ff;
    nxt_err       = err_ff;
    nxt_to_module = to_module_ff;
    nxt_bank      = bank_ff;
    nxt_sys       = sys_ff;
    nxt_combined  = combined_ff;
    nxt_phase     = 1'b0;
    unique case (state_ff)
      bmt_pkg::ST_IDLE: begin
        if (sampled_ff) begin
          if (mode_bad) begin
            nxt_err.mode_err = 1'b1;
            nxt_state        = bmt_pkg::ST_ERROR;
          end else if (start_auto) begin
            nxt_state = bmt_pkg::ST_PREP;
          end else if (sw_ff.manual_mode_select) begin
            nxt_state = bmt_pkg::ST_MANUAL;
          end
        end
      end
      bmt_pkg::ST_MANUAL: begin
        if (manual_go) begin
          nxt_state = bmt_pkg::ST_PREP;
        end
      end
      bmt_pkg::ST_PREP: begin
        // terminal configuration is never consulted here
        nxt_to_module = want_module_dst;
        nxt_bank      = sw_ff.manual_mode_select ? panel_bank : sel_bank;
        nxt_sys       = sel_sys;
        nxt_combined  = combined;
        if (protect_bad) begin
          nxt_err.protect_err = 1'b1;
          nxt_state           = bmt_pkg::ST_ERROR;
        end else if (data_bad) begin
          nxt_err.data_err = 1'b1;
          nxt_state        = bmt_pkg::ST_ERROR;
        end else begin
          nxt_state = bmt_pkg::ST_XMIT;
        end
      end
      bmt_pkg::ST_XMIT: begin
        if (last_popped) begin
          nxt_state = bmt_pkg::ST_VERIFY;
        end
      end
      bmt_pkg::ST_VERIFY: begin
        nxt_phase = 1'b1;
        if (phase_ff & verify_done) begin
          if (verify_ok) begin
            nxt_state = bmt_pkg::ST_DONE;
          end else begin
            nxt_err.data_err = 1'b1;
            nxt_state        = bmt_pkg::ST_ERROR;
          end
        end
      end
      bmt_pkg::ST_DONE:  nxt_state = bmt_pkg::ST_DONE;
      bmt_pkg::ST_ERROR: nxt_state = bmt_pkg::ST_ERROR;
      default:           nxt_state = bmt_pkg::ST_ERROR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= bmt_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_ff <= '0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      to_module_ff <= 1'b0;
    end else begin
      to_module_ff <= nxt_to_module;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_ff <= 1'b0;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_ff <= 1'b0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      combined_ff <= 1'b0;
    end else begin
      combined_ff <= nxt_combined;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // one-shot switch capture after reset release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_ff <= '0;
    end else if (!sampled_ff) begin
      sw_ff <= switches;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampled_ff <= 1'b0;
    end else begin
      sampled_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_once_ff <= 1'b0;
    end else if (state_ff == bmt_pkg::ST_PREP) begin
      done_once_ff <= 1'b1;
    end
  end

  // buffer storage, one slot per entry
  for (genvar i = 0; i < bmt_pkg::BUF_DEPTH; i++) begin : g_buf
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        buf_ff[i] <= '0;
      end else if (push && (wptr_ff == 1'(i))) begin
        buf_ff[i]      <= src_word;
        buf_ff[i].bank <= word_bank;
        buf_ff[i].last <= src_last;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_ff <= 1'b0;
    end else begin
      wptr_ff <= wptr_ff ^ push;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rptr_ff <= 1'b0;
    end else begin
      rptr_ff <= rptr_ff ^ pop;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
    end
  end

  // run lamp: slow blink preparing, fast blink moving, steady when done; dark throughout manual runs
  wire logic        manual_run = sw_ff.manual_mode_select;
  wire logic        fast_phase = xmit_active | (state_ff == bmt_pkg::ST_VERIFY);
  wire logic [25:0] blink_end  = fast_phase ? 26'(bmt_pkg::FAST_FLASH_CYC - 1)
                                            : 26'(bmt_pkg::SLOW_FLASH_CYC - 1);
  wire logic        blink_wrap = (blink_ff >= blink_end);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      verr_ff <= 1'b0;
    end else begin
      verr_ff <= fast_phase;
    end
  end

  // restart the interval whenever the blink rate changes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_ff <= 26'h0000000;
    end else begin
      blink_ff <= (blink_wrap || (verr_ff != fast_phase)) ? 26'h0000000 : blink_ff + 26'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lamp_ff <= 1'b0;
    end else begin
      if (manual_run || state_ff == bmt_pkg::ST_ERROR || state_ff == bmt_pkg::ST_IDLE
          || state_ff == bmt_pkg::ST_MANUAL) begin
        lamp_ff <= 1'b0;
      end else if (state_ff == bmt_pkg::ST_DONE) begin
        lamp_ff <= 1'b1;
      end else if (blink_wrap) begin
        lamp_ff <= ~lamp_ff;
      end
    end
  end

endmodule // bmt_transfer_ctrl

// File: logic/bmt_pkg.sv
// package for the backup module transfer controller
// assumes one 50 MHz clock and a synchronous active-high reset
package bmt_pkg;

  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned SLOW_FLASH_MS   = 1000;
  localparam int unsigned FAST_FLASH_MS   = 500;
  localparam int unsigned SLOW_FLASH_CYC  = CLK_HZ / 1000 * SLOW_FLASH_MS;
  localparam int unsigned FAST_FLASH_CYC  = CLK_HZ / 1000 * FAST_FLASH_MS;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned ADDR_W          = 20;
  localparam int unsigned BUF_DEPTH       = 2;
  localparam logic        BANK_SYS        = 1'b0;
  localparam logic        BANK_SCR        = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

  typedef struct packed {
    logic restore_mode_select;
    logic backup_mode_select;
    logic manual_mode_select;
    logic data_type_select;
    logic terminal_write_enable;
    logic module_write_enable;
    logic bank_select;
    logic combined_transfer_enable;
  } bmt_switch_s;

  typedef struct packed {
    logic mode_err;
    logic protect_err;
    logic data_err;
  } bmt_err_s;

  typedef struct packed {
    logic              bank;
    logic              sys_area;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              last;
  } bmt_word_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PREP    = 3'b001,
    ST_XMIT    = 3'b011,
    ST_VERIFY  = 3'b010,
    ST_DONE    = 3'b110,
    ST_ERROR   = 3'b111,
    ST_MANUAL  = 3'b101
  } bmt_state_e;

endpackage : bmt_pkg

// File: sim/bmt_mem_model.sv
// far-side model: two-bank backup storage that streams and sinks words
// assumes the controller's valid/ready handshakes on one clock
`timescale 1ns/1ps
module bmt_mem_model (
  input  wire logic               clk,           // clock
  input  wire logic               sys_rst,       // reset
  input  wire logic               stall,         // slow sink
  input  wire logic               ok_cfg,        // verify result
  input  wire logic               src_request,   // stream wanted
  input  wire logic               src_ready,     // word taken
  input  wire logic               src_bank,      // bank read
  output logic                    src_valid,     // word offered
  output bmt_pkg::bmt_word_s      src_word,      // word
  output logic                    src_last,      // final word
  input  wire logic               dst_valid,     // write offered
  input  wire logic               dst_to_module, // writes to banks
  input  wire bmt_pkg::bmt_word_s dst_word,      // write word
  output logic                    dst_ready,     // write taken
  input  wire logic               verify_start,  // verify pulse
  output logic                    verify_done,   // verify over
  output logic                    verify_ok,     // verify match
  output logic [3:0]              wr0_cnt,       // bank 0 writes
  output logic [3:0]              wr1_cnt        // bank 1 writes
);
  logic [2:0] idx_ff;
  logic       tog_ff;
  logic [1:0] vfy_ff;
  wire        take = src_valid & src_ready;
  wire        put  = dst_valid & dst_ready & dst_to_module;
  assign src_valid   = src_request & ~idx_ff[2];
  assign src_last    = idx_ff == 3'h3;
  assign src_word    = {src_bank, idx_ff[0], 17'h00000, idx_ff, 5'h00, idx_ff, src_last};
  assign dst_ready   = ~stall | tog_ff;
  assign verify_done = vfy_ff == 2'h2;
  assign verify_ok   = ok_cfg;
  always_ff @(posedge clk) begin
    tog_ff <= ~tog_ff & ~sys_rst;
    idx_ff <= (sys_rst | ~src_request) ? 3'h0 : idx_ff + {2'h0, take};
    vfy_ff <= sys_rst ? 2'h0 : verify_start ? 2'h1 : (vfy_ff == 2'h1) ? 2'h2 : vfy_ff;
    wr0_cnt <= sys_rst ? 4'h0 : wr0_cnt + {3'h0, put & ~dst_word.bank};
    wr1_cnt <= sys_rst ? 4'h0 : wr1_cnt + {3'h0, put & dst_word.bank};
  end
endmodule // bmt_mem_model

// File: sim/bmt_transfer_ctrl_chk.sv
// checker bound onto the transfer controller's ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module bmt_transfer_ctrl_chk (
  input wire logic                 clk,             // clock
  input wire logic                 sys_rst,         // reset
  input wire bmt_pkg::bmt_switch_s switches,        // selectors
  input wire logic                 module_present,  // attached
  input wire logic                 src_request,     // stream wanted
  input wire logic                 dst_valid,       // write valid
  input wire logic                 dst_ready,       // write taken
  input wire bmt_pkg::bmt_word_s   dst_word,        // write word
  input wire logic                 verify_start,    // verify pulse
  input wire bmt_pkg::bmt_err_s    err_flags,       // error class
  input wire bmt_pkg::bmt_state_e  xfer_state,      // progress
  input wire logic                 run_lamp,        // lamp
  input wire logic                 normal_run_allow // run allowed
);
  logic [1:0] age_ff;
  logic       man_ff;
  wire  [1:0] nxt_age  = sys_rst ? 2'h0 : age_ff + {1'b0, age_ff != 2'h3};
  wire  [1:0] modes_on = 2'(switches.restore_mode_select) + 2'(switches.backup_mode_select)
                       + 2'(switches.manual_mode_select);
  wire        one_mode = modes_on == 2'h1;
  wire        in_done  = xfer_state == bmt_pkg::ST_DONE;
  wire        any_err  = err_flags != 3'h0;
  always_ff @(posedge clk) age_ff <= nxt_age;
  always_ff @(posedge clk) man_ff <= (age_ff == 2'h0) ? switches.manual_mode_select : man_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // capture edge together with a switch condition
  sequence s_cap(c);
    age_ff == 2'h0 && c;
  endsequence
  sequence s_auto_done;
    (in_done && !man_ff) [*2];
  endsequence
  a_mode_err: assert property (s_cap(!one_mode) |-> ##[1:3] err_flags.mode_err)
    else $error("mode error missing");
  a_prot_bkp: assert property (
    s_cap(one_mode && switches.backup_mode_select && !switches.module_write_enable)
    |-> ##[1:3] err_flags.protect_err) else $error("module protect error missing");
  a_prot_rst: assert property (
    s_cap(one_mode && switches.restore_mode_select && !switches.terminal_write_enable)
    |-> ##[1:3] err_flags.protect_err) else $error("terminal protect error missing");
  a_err_nowr: assert property (any_err |-> !dst_valid) else $error("write after error");
  a_err_hold: assert property (any_err |=> $stable(err_flags)) else $error("error moved");
  a_dst_hold: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_word))
    else $error("write word dropped");
  a_vfy_pulse: assert property (verify_start |=> !verify_start &&
    xfer_state == bmt_pkg::ST_VERIFY) else $error("verify pulse wrong");
  a_done_lamp: assert property (s_auto_done |-> run_lamp) else $error("lamp not lit");
  a_done_hold: assert property (in_done |=> in_done) else $error("left finished");
  a_no_run: assert property (module_present |-> !normal_run_allow)
    else $error("run allowed with module");
  a_xmit_req: assert property (src_request == (xfer_state == bmt_pkg::ST_XMIT))
    else $error("stream request wrong");
endmodule // bmt_transfer_ctrl_chk
bind bmt_transfer_ctrl bmt_transfer_ctrl_chk u_chk (.*);

// File: sim/backup_module_transfer_control_tb.sv
// testbench for the backup module transfer controller
// assumes the far-side storage model and the bound checker
`timescale 1ns/1ps
module backup_module_transfer_control_tb;
  localparam logic [2:0] DN = bmt_pkg::ST_DONE;
  localparam logic [2:0] ER = bmt_pkg::ST_ERROR;
  localparam logic [2:0] MN = bmt_pkg::ST_MANUAL;
  logic clk, sys_rst, module_present, bank0_holds_sys, bank1_holds_sys, panel_execute;
  logic panel_to_module, panel_bank, src_valid, src_ready, src_last, src_request;
  logic src_from_module, src_bank, src_sys, dst_valid, dst_ready, dst_to_module;
  logic verify_done, verify_ok, verify_start, run_lamp, normal_run_allow, stall, ok_cfg;
  logic [3:0]           wr0_cnt, wr1_cnt;
  bmt_pkg::bmt_switch_s switches;
  bmt_pkg::bmt_word_s   src_word, dst_word;
  bmt_pkg::bmt_err_s    err_flags;
  bmt_pkg::bmt_state_e  xfer_state;
  int                   bad_count, checks_done, cyc;
  bmt_transfer_ctrl u_dut (.*);
  bmt_mem_model     u_mem (.*);
  always #10 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic run(input logic [7:0] s, input logic [1:0] b, input logic ok,
                     input logic [2:0] p, input logic [2:0] st, input logic [2:0] er,
                     input logic [7:0] wr);
    int n;
    @(posedge clk);
    #1 sys_rst = 1'b1;
    switches = s;
    {bank1_holds_sys, bank0_holds_sys} = b;
    ok_cfg = ok;
    {panel_execute, panel_to_module, panel_bank} = p;
    stall = ~stall;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 switches = ~s;
    for (n = 0; n < 120 && xfer_state !== DN && xfer_state !== ER; n++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1 chk(xfer_state, st);
    chk(err_flags, er);
    chk({wr1_cnt, wr0_cnt}, wr);
    chk(run_lamp, st == DN && !s[5]);
    chk(normal_run_allow, 1'b0);
    if (st == DN) begin
      chk(dst_to_module, s[5] ? p[1] : s[6]);
      chk(src_from_module, s[5] ? !p[1] : !s[6]);
      chk(src_bank, s[5] ? p[0] : s[1]);
      chk(src_sys, s[4]);
    end
    $display("test done at %0t", $time);
  endtask
  initial begin
    {clk, sys_rst, module_present, stall, ok_cfg} = 5'b01101;
    {bank0_holds_sys, bank1_holds_sys, panel_execute, panel_to_module, panel_bank} = 5'h00;
    switches = 8'h00;
    {bad_count, checks_done, cyc} = '0;
    run(8'h0C, 2'h0, 1'b1, 3'h0, ER, 3'h4, 8'h00);
    run(8'hCC, 2'h0, 1'b1, 3'h0, ER, 3'h4, 8'h00);
    run(8'hEC, 2'h0, 1'b1, 3'h0, ER, 3'h4, 8'h00);
    run(8'h48, 2'h0, 1'b1, 3'h0, ER, 3'h2, 8'h00);
    run(8'h84, 2'h0, 1'b1, 3'h0, ER, 3'h2, 8'h00);
    run(8'h9C, 2'h0, 1'b1, 3'h0, ER, 3'h1, 8'h00);
    run(8'h8E, 2'h2, 1'b1, 3'h0, ER, 3'h1, 8'h00);
    run(8'h8D, 2'h3, 1'b1, 3'h0, ER, 3'h1, 8'h00);
    run(8'h8D, 2'h0, 1'b1, 3'h0, ER, 3'h1, 8'h00);
    run(8'h4E, 2'h0, 1'b1, 3'h0, DN, 3'h0, 8'h40);
    run(8'h54, 2'h0, 1'b1, 3'h0, DN, 3'h0, 8'h04);
    run(8'h45, 2'h0, 1'b1, 3'h0, DN, 3'h0, 8'h22);
    run(8'h88, 2'h0, 1'b1, 3'h0, DN, 3'h0, 8'h00);
    run(8'h89, 2'h1, 1'b1, 3'h0, DN, 3'h0, 8'h00);
    run(8'h9A, 2'h2, 1'b1, 3'h0, DN, 3'h0, 8'h00);
    run(8'h4E, 2'h0, 1'b0, 3'h0, ER, 3'h1, 8'h40);
    run(8'h2C, 2'h0, 1'b1, 3'h0, MN, 3'h0, 8'h00);
    run(8'h2C, 2'h0, 1'b1, 3'h7, DN, 3'h0, 8'h40);
    run(8'h2C, 2'h0, 1'b1, 3'h4, DN, 3'h0, 8'h00);
    run(8'h3C, 2'h2, 1'b1, 3'h5, DN, 3'h0, 8'h00);
    @(posedge clk);
    #1 module_present = 1'b0;
    @(posedge clk);
    #1 chk(normal_run_allow, 1'b1);
    end_sim();
  end
endmodule // backup_module_transfer_control_tb
